// ---- hw/phase_c_cfg_pkg.sv ----
/*
 * Constants shared by the phase-C select and sense configuration block:
 * register addresses, reset values, field positions, selection codes and
 * the guard time that qualifies back-EMF sampling.
 * Assumes a 100 MHz core clock.
 */
package phase_c_cfg_pkg;

   // Register addresses on the serial register port.
   localparam logic [7:0] ADDR_DRIVER_SELECT = 8'h0c;
   localparam logic [7:0] ADDR_GAIN_CONTROL = 8'h0d;
   localparam logic [7:0] ADDR_SAMPLE_CONTROL = 8'h0e;
   localparam logic [7:0] ADDR_THRESHOLD_CONTROL = 8'h0f;

   // Reset values.
   localparam logic [7:0] RESET_DRIVER_SELECT = 8'h36;
   localparam logic [7:0] RESET_GAIN_CONTROL = 8'haa;
   localparam logic [7:0] RESET_SAMPLE_CONTROL = 8'h00;
   localparam logic [7:0] RESET_THRESHOLD_CONTROL = 8'h88;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Field positions of the driver select register.
   localparam int HYSTERESIS_BIT = 7;
   localparam int HIGH_SOURCE_MSB = 6;
   localparam int HIGH_SOURCE_LSB = 4;
   localparam int PUMP_UV_BIT = 3;
   localparam int LOW_SOURCE_MSB = 2;
   localparam int LOW_SOURCE_LSB = 0;

   // Field positions of the gain register; amplifier n at 7-2n : 6-2n.
   localparam int BACKEMF_GAIN_MSB = 7;
   localparam int BACKEMF_GAIN_LSB = 6;
   localparam int AMP_GAIN_TOP = 5;

   // Field positions of the sample control register.
   localparam int CAL_INPUT_BIT = 7;
   localparam int PHASE_SEL_MSB = 6;
   localparam int PHASE_SEL_LSB = 4;
   localparam int BEMF_HOLD_BIT = 3;
   localparam int AMP_HOLD_TOP = 2;

   // Field positions of the threshold register.
   localparam int CMP1_THRESH_MSB = 7;
   localparam int CMP1_THRESH_LSB = 4;
   localparam int CMP2_THRESH_MSB = 3;
   localparam int CMP2_THRESH_LSB = 0;

   // Codes.
   localparam logic [2:0] SOURCE_FORCE_LOW = 3'h0;
   localparam logic [2:0] SOURCE_FLOAT = 3'h7;
   localparam logic [1:0] PHASE_AUTO_TOP = 2'h0;
   localparam logic [2:0] PHASE_BY_CMP12 = 3'h2;
   localparam logic [2:0] PHASE_BY_CMP13 = 3'h3;
   localparam logic [1:0] BACKEMF_GAIN_AMP3_CODE = 2'h0;
   localparam logic [3:0] THRESHOLD_OFF = 4'h0;

   // Guard time after PWM on before back-EMF sampling, least time.
   localparam int CLK_PERIOD_NS = 10;
   localparam int GUARD_TIME_NS = 500;
   localparam logic [15:0] GUARD_CYCLES =
      16'((GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Back-EMF detect phase, encoded as the comparator pin pair reads.
   typedef enum logic [1:0] {
      PHASE_NONE,
      PHASE_A,
      PHASE_B,
      PHASE_C
   } bemf_phase_t;

   // True when a source code turns the driver off completely.
   function automatic logic sourceFloats(input logic [2:0] code);
      return code == SOURCE_FLOAT;
   endfunction

endpackage

// ---- hw/gate_source_mux.sv ----
/*
 * Source selector for one gate driver: picks forced low, one of six gate
 * inputs, or floating.
 * Assumes gate inputs already synchronised to the core clock.
 */
module gate_source_mux
   import phase_c_cfg_pkg::*;
(
   input wire logic [2:0] sourceCode,
   input wire logic [5:0] gateIn,
   output logic driveLevel,
   output logic driveEnable
);

   wire logic picksInput;
   wire logic [2:0] inputIndex;

   // Codes one to six map onto gate inputs one to six.
   assign picksInput = (sourceCode != SOURCE_FORCE_LOW) &&
                       !sourceFloats(sourceCode);
   assign inputIndex = sourceCode - 3'h1;

   // Forced low drives a low level; floating turns source and sink off.
   assign driveLevel = picksInput ? gateIn[inputIndex] : 1'b0;
   assign driveEnable = !sourceFloats(sourceCode);

endmodule

// ---- hw/bemf_phase_select.sv ----
/*
 * Back-EMF detect phase selection: automatic from the gate inputs at each
 * sample strobe falling edge, from comparator pin pairs, or fixed.
 * Assumes all inputs are synchronised to clk.
 */
module bemf_phase_select
   import phase_c_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] phaseMode,
   input wire logic strobeFall,
   input wire logic [5:0] gateIn,
   input wire logic [2:0] cmpIn,
   output bemf_phase_t phase
);

   bemf_phase_t autoPhase_q;
   bemf_phase_t autoPhase_d;
   wire logic [2:0] idle;

   // A phase whose high and low inputs are both low is the floating one.
   assign idle[0] = !gateIn[0] && !gateIn[1];
   assign idle[1] = !gateIn[2] && !gateIn[3];
   assign idle[2] = !gateIn[4] && !gateIn[5];

   // Exactly one idle phase is taken; anything else means no phase.
   always_comb begin
      case (idle)
         3'h1: autoPhase_d = PHASE_A;
         3'h2: autoPhase_d = PHASE_B;
         3'h4: autoPhase_d = PHASE_C;
         default: autoPhase_d = PHASE_NONE;
      endcase
   end

   // The automatic choice only moves on a strobe falling edge.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         autoPhase_q <= PHASE_NONE;
      end else begin
         autoPhase_q <= strobeFall ? autoPhase_d : autoPhase_q; // RL9
      end
   end

   // Mode decode; the fixed codes carry the phase in their low bits.
   always_comb begin
      if (phaseMode[2:1] == PHASE_AUTO_TOP) begin
         phase = autoPhase_q; // RL9
      end else if (phaseMode == PHASE_BY_CMP12) begin
         phase = bemf_phase_t'({cmpIn[0], cmpIn[1]}); // RL10
      end else if (phaseMode == PHASE_BY_CMP13) begin
         phase = bemf_phase_t'({cmpIn[0], cmpIn[2]}); // RL11
      end else begin
         phase = bemf_phase_t'(phaseMode[1:0]); // RL12
      end
   end

endmodule

// ---- hw/phase_c_select_and_sense_config.sv ----
/*
 * Phase-C gate source selection and sense configuration registers, with
 * the selection, sample/hold and back-EMF phase logic they steer.
 * Assumes a register port already decoded from the serial interface, and
 * pins (gate inputs, sample strobe, comparator outputs) that arrive
 * asynchronously and are synchronised here.
 */

// Summary of operation
// (RL1) High-side source code picks low, input, float.
// (RL2) Low-side source code uses the same encoding.
// (RL3) Code 111b turns the driver fully off.
// (RL4) Bit 7 clear gives comparator 3 hysteresis.
// (RL5) Bit 3 picks pump undervoltage threshold ratio.
// (RL6) Back-EMF gain applies when amplifier 3 code 00b.
// (RL7) Three sense gain fields pick 5 to 40.
// (RL8) Calibration bit ties back-EMF inputs to reference.
// (RL9) Codes 00x pick phase at strobe fall.
// (RL10) Code 010b decodes comparators one and two.
// (RL11) Code 011b decodes comparators one and three.
// (RL12) Codes 100b to 111b fix the phase.
// (RL13) Back-EMF holds unless strobe low, PWM, guarded.
// (RL14) Sense amplifier holds unless strobe is low.
// (RL15) Comparator one threshold, zero disables it.
// (RL16) Comparator two threshold, zero disables it.
// (RL17) Registers reset to 36h, aah, 00h, 88h.
// (RL18) All fields read back and act at once; drive, phase, sampling and derived enable outputs lag one more edge.
// (RL19) Selected gate input level drives phase C.
module phase_c_select_and_sense_config
   import phase_c_cfg_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,

   // Register port.
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   output logic [7:0] regReadData,

   // Host pins, asynchronous to clk.
   input wire logic [5:0] gateInput,
   input wire logic sampleStrobe_n,
   input wire logic comparator1Output,
   input wire logic comparator2Output,
   input wire logic comparator3Output,

   // Phase-C drive controls.
   output logic highDriveLevel,
   output logic highDriveEnable,
   output logic lowDriveLevel,
   output logic lowDriveEnable,

   // Analog settings and sampling.
   output logic comparator3HysteresisOff,
   output logic pumpUvThresholdHigh,
   output logic [1:0] backemfGain,
   output logic backemfGainActive,
   output logic [1:0] senseAmp1Gain,
   output logic [1:0] senseAmp2Gain,
   output logic [1:0] senseAmp3Gain,
   output logic bemfInputsToReference,
   output logic [1:0] bemfPhase,
   output logic backemfSampling,
   output logic [2:0] senseAmpSampling,
   output logic comparator1Enable,
   output logic [3:0] comparator1Threshold,
   output logic comparator2Enable,
   output logic [3:0] comparator2Threshold
);

   // A write shows on field outputs one edge later and on drive,
   // phase and sampling outputs two edges later; a pin change takes
   // three, or four for the automatic phase. The extra flop trades latency for clean analog levels,
   // so a host must wait that long before relying on the effect.

   // Register state and next values.
   logic [7:0] driverSelect_q;
   logic [7:0] driverSelect_d;
   logic [7:0] gainControl_q;
   logic [7:0] gainControl_d;
   logic [7:0] sampleControl_q;
   logic [7:0] sampleControl_d;
   logic [7:0] thresholdControl_q;
   logic [7:0] thresholdControl_d;

   // Read data holds until the next read strobe.
   logic [7:0] readData_q;
   logic [7:0] readData_d;

   // Pin synchronisers, two stages each.
   logic [5:0] gateSyncA_q;
   logic [5:0] gateSync_q;
   logic strobeSyncA_q;
   logic strobeSync_q;

   // Strobe delay for edge detect; resets high, the idle level.
   logic strobePrev_q;
   logic [2:0] cmpSyncA_q;
   logic [2:0] cmpSync_q;

   // Guard timer for back-EMF sampling after PWM turns on.
   logic [15:0] guardCount_q;
   logic [15:0] guardCount_d;

   // Flopped outputs.
   logic highLevel_q;
   logic highEnable_q;
   logic lowLevel_q;
   logic lowEnable_q;
   logic bemfSampling_q;
   logic [2:0] ampSampling_q;
   logic [1:0] phase_q;

   // Decoded fields and intermediate terms.
   wire logic hitDriver;
   wire logic hitGain;
   wire logic hitSample;
   wire logic hitThreshold;

   // Fields and pin terms.
   wire logic [2:0] highSource;
   wire logic [2:0] lowSource;
   wire logic [2:0] phaseMode;
   wire logic [2:0] ampHold;
   wire logic [3:0] cmp1Thresh;
   wire logic [3:0] cmp2Thresh;
   wire logic strobeLow;
   wire logic strobeFall;
   wire logic pwmOn;
   wire logic guardDone;
   wire logic bemfSampling_d;
   wire logic [2:0] ampSampling_d;

   // Selector and phase results.
   wire logic [5:0] muxLevel;
   wire logic [1:0] muxLevelOut;
   wire logic [1:0] muxEnableOut;
   wire logic [5:0] muxCodes;
   bemf_phase_t selectedPhase;

   // Address decode of the register port.
   assign hitDriver = regAddr == ADDR_DRIVER_SELECT;
   assign hitGain = regAddr == ADDR_GAIN_CONTROL;
   assign hitSample = regAddr == ADDR_SAMPLE_CONTROL;
   assign hitThreshold = regAddr == ADDR_THRESHOLD_CONTROL;

   // Writes land in full; every field is plain read/write.
   assign driverSelect_d = (regWrite && hitDriver) ?
                           regWriteData : driverSelect_q; // RL18
   assign gainControl_d = (regWrite && hitGain) ?
                          regWriteData : gainControl_q; // RL18
   assign sampleControl_d = (regWrite && hitSample) ?
                            regWriteData : sampleControl_q; // RL18
   assign thresholdControl_d = (regWrite && hitThreshold) ?
                               regWriteData : thresholdControl_q; // RL18

   // Read mux; addresses outside the four registers read as zero.
   assign readData_d = !regRead ? readData_q :
                       hitDriver ? driverSelect_q :
                       hitGain ? gainControl_q :
                       hitSample ? sampleControl_q :
                       hitThreshold ? thresholdControl_q :
                       READ_UNMAPPED; // RL18

   // Register storage with documented reset values.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         driverSelect_q <= RESET_DRIVER_SELECT; // RL17
         gainControl_q <= RESET_GAIN_CONTROL; // RL17
         sampleControl_q <= RESET_SAMPLE_CONTROL; // RL17
         thresholdControl_q <= RESET_THRESHOLD_CONTROL; // RL17
         readData_q <= READ_UNMAPPED;
      end else begin
         driverSelect_q <= driverSelect_d;
         gainControl_q <= gainControl_d;
         sampleControl_q <= sampleControl_d;
         thresholdControl_q <= thresholdControl_d;
         readData_q <= readData_d;
      end
   end

   // Two-stage synchronisers; only the second stage feeds any logic.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gateSyncA_q <= 6'h00;
         gateSync_q <= 6'h00;
         strobeSyncA_q <= 1'b1;
         strobeSync_q <= 1'b1;
         strobePrev_q <= 1'b1;
         cmpSyncA_q <= 3'h0;
         cmpSync_q <= 3'h0;
      end else begin
         gateSyncA_q <= gateInput;
         gateSync_q <= gateSyncA_q;
         strobeSyncA_q <= sampleStrobe_n;
         strobeSync_q <= strobeSyncA_q;
         strobePrev_q <= strobeSync_q;
         cmpSyncA_q <= {comparator3Output, comparator2Output,
                        comparator1Output};
         cmpSync_q <= cmpSyncA_q;
      end
   end

   // Field extraction.
   assign highSource = driverSelect_q[HIGH_SOURCE_MSB:HIGH_SOURCE_LSB];
   assign lowSource = driverSelect_q[LOW_SOURCE_MSB:LOW_SOURCE_LSB];
   assign phaseMode = sampleControl_q[PHASE_SEL_MSB:PHASE_SEL_LSB];
   assign ampHold = sampleControl_q[AMP_HOLD_TOP:0];
   assign cmp1Thresh = thresholdControl_q[CMP1_THRESH_MSB:CMP1_THRESH_LSB];
   assign cmp2Thresh = thresholdControl_q[CMP2_THRESH_MSB:CMP2_THRESH_LSB];
   // Strobe terms read the second sync stage and its delayed copy.
   assign strobeLow = !strobeSync_q;
   assign strobeFall = strobePrev_q && !strobeSync_q;

   // One source selector per driver, high side first.
   assign muxCodes = {lowSource, highSource};
   assign muxLevel = gateSync_q;

   generate
      for (genvar side = 0; side < 2; side++) begin : gen_driver
         gate_source_mux u_mux (
            .sourceCode(muxCodes[side*3 +: 3]), // RL1 RL2
            .gateIn(muxLevel),
            .driveLevel(muxLevelOut[side]),
            .driveEnable(muxEnableOut[side])
         );
      end
   endgenerate

   // Back-EMF detect phase selection.
   bemf_phase_select u_phase (
      .clk(clk),
      .reset(reset),
      .phaseMode(phaseMode),
      .strobeFall(strobeFall),
      .gateIn(gateSync_q),
      .cmpIn(cmpSync_q),
      .phase(selectedPhase)
   );

   // PWM counts as on while the phase-C high side is driven high. The
   // guard delay keeps switching ringing out of the back-EMF sample.
   assign pwmOn = muxLevelOut[0] && muxEnableOut[0];
   assign guardDone = guardCount_q >= GUARD_CYCLES;
   assign guardCount_d = !pwmOn ? 16'h0000 :
                         guardDone ? guardCount_q :
                         guardCount_q + 16'h0001;

   // Guard counter restarts whenever PWM drops.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         guardCount_q <= 16'h0000;
      end else begin
         guardCount_q <= guardCount_d;
      end
   end

   // Sample/hold: a clear bit samples continuously, a set bit only in
   // the strobe low window, qualified for back-EMF by the guarded PWM.
   assign bemfSampling_d = !sampleControl_q[BEMF_HOLD_BIT] ||
                           (strobeLow && pwmOn && guardDone); // RL13

   generate
      for (genvar amp = 0; amp < 3; amp++) begin : gen_amp_hold
         // Bit 2 is amplifier one, so amplifier order is reversed.
         assign ampSampling_d[amp] =
            !ampHold[AMP_HOLD_TOP - amp] || strobeLow; // RL14
      end
   endgenerate

   // Drive, sampling and phase outputs are flopped so the analog side
   // sees glitch-free levels, at the cost of one cycle of latency.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         highLevel_q <= 1'b0;
         highEnable_q <= 1'b1;
         lowLevel_q <= 1'b0;
         lowEnable_q <= 1'b1;
         bemfSampling_q <= 1'b1;
         ampSampling_q <= 3'h7;
         phase_q <= PHASE_NONE;
      end else begin
         highLevel_q <= muxLevelOut[0]; // RL19
         highEnable_q <= muxEnableOut[0]; // RL3
         lowLevel_q <= muxLevelOut[1]; // RL19
         lowEnable_q <= muxEnableOut[1]; // RL3
         bemfSampling_q <= bemfSampling_d;
         ampSampling_q <= ampSampling_d;
         phase_q <= selectedPhase;
      end
   end

   // Top outputs come straight from flops.
   assign highDriveLevel = highLevel_q;
   assign highDriveEnable = highEnable_q;
   assign lowDriveLevel = lowLevel_q;
   assign lowDriveEnable = lowEnable_q;
   assign backemfSampling = bemfSampling_q;
   assign senseAmpSampling = ampSampling_q;
   assign bemfPhase = phase_q;
   assign regReadData = readData_q;

   // Analog settings come straight off the register bits.
   assign comparator3HysteresisOff = driverSelect_q[HYSTERESIS_BIT]; // RL4
   assign pumpUvThresholdHigh = driverSelect_q[PUMP_UV_BIT]; // RL5
   assign backemfGain = gainControl_q[BACKEMF_GAIN_MSB:BACKEMF_GAIN_LSB]; // RL6
   assign senseAmp1Gain = gainControl_q[AMP_GAIN_TOP -: 2]; // RL7
   assign senseAmp2Gain = gainControl_q[AMP_GAIN_TOP - 2 -: 2]; // RL7
   assign senseAmp3Gain = gainControl_q[AMP_GAIN_TOP - 4 -: 2]; // RL7
   assign bemfInputsToReference = !sampleControl_q[CAL_INPUT_BIT]; // RL8
   assign comparator1Threshold = cmp1Thresh; // RL15
   assign comparator2Threshold = cmp2Thresh; // RL16

   // Derived enables are flopped; they follow the register by one cycle.
   logic gainActive_q;
   logic cmp1Enable_q;
   logic cmp2Enable_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gainActive_q <= 1'b0;
         cmp1Enable_q <= 1'b1;
         cmp2Enable_q <= 1'b1;
      end else begin
         gainActive_q <= gainControl_q[AMP_GAIN_TOP - 4 -: 2] ==
                         BACKEMF_GAIN_AMP3_CODE; // RL6
         cmp1Enable_q <= cmp1Thresh != THRESHOLD_OFF; // RL15
         cmp2Enable_q <= cmp2Thresh != THRESHOLD_OFF; // RL16
      end
   end

   // Derived enables leave through their flops.
   assign backemfGainActive = gainActive_q;
   assign comparator1Enable = cmp1Enable_q;
   assign comparator2Enable = cmp2Enable_q;

endmodule

// ---- verif/phase_c_cfg_assertions.sv ----
/*
 * Port assertions for the phase-C select and sense block.
 * Assumes it is bound to the block top and shares its clock and reset.
 */
module phase_c_cfg_assertions
   import phase_c_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic [7:0] regReadData,
   input wire logic sampleStrobe_n,
   input wire logic highDriveLevel,
   input wire logic highDriveEnable,
   input wire logic lowDriveEnable,
   input wire logic comparator3HysteresisOff,
   input wire logic backemfGainActive,
   input wire logic [1:0] bemfPhase,
   input wire logic [2:0] senseAmpSampling,
   input wire logic comparator1Enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Per-register write strobes; derived outputs land two edges later.
   wire selWr = regWrite && regAddr == ADDR_DRIVER_SELECT;
   wire gainWr = regWrite && regAddr == ADDR_GAIN_CONTROL;
   wire smpWr = regWrite && regAddr == ADDR_SAMPLE_CONTROL;
   wire thrWr = regWrite && regAddr == ADDR_THRESHOLD_CONTROL;
   a_high_floats:
   assert property (selWr && regWriteData[6:4] == 3'h7
      |-> ##2 !highDriveEnable) else $error("high side not floating");
   a_low_floats:
   assert property (selWr && regWriteData[2:0] == 3'h7
      |-> ##2 !lowDriveEnable) else $error("low side not floating");
   a_high_forced_low:
   assert property (selWr && regWriteData[6:4] == 3'h0
      |-> ##2 highDriveEnable && !highDriveLevel) else $error("not low");
   a_hysteresis_bit:
   assert property (selWr |=> comparator3HysteresisOff ==
      $past(regWriteData[7])) else $error("hysteresis bit wrong");
   a_gain_active:
   assert property (gainWr && regWriteData[1:0] == 2'h0
      |-> ##2 backemfGainActive) else $error("gain not active");
   a_cmp1_disabled:
   assert property (thrWr && regWriteData[7:4] == 4'h0
      |-> ##2 !comparator1Enable) else $error("comparator on");
   a_phase_fixed:
   assert property (smpWr && regWriteData[6] |-> ##2
      bemfPhase == $past(regWriteData[5:4], 2)) else $error("bad phase");
   a_strobe_samples:
   assert property ((!sampleStrobe_n) [*4] |-> senseAmpSampling == 3'h7)
      else $error("sense amp holding");
   a_unmapped_zero:
   assert property (regRead && (regAddr < 8'h0c || regAddr > 8'h0f)
      |=> regReadData == 8'h00) else $error("unmapped read not zero");
endmodule

bind phase_c_select_and_sense_config phase_c_cfg_assertions u_chk (.clk,
   .reset, .regWrite, .regRead, .regAddr, .regWriteData, .regReadData,
   .sampleStrobe_n, .highDriveLevel, .highDriveEnable, .lowDriveEnable,
   .comparator3HysteresisOff, .backemfGainActive, .bemfPhase,
   .senseAmpSampling, .comparator1Enable);

// ---- verif/host_model.sv ----
/*
 * Host controller model: register strobes and pin levels.
 * Assumes the bench calls its tasks; every change lands on a falling edge.
 */
module host_model (
   input wire logic clk,
   input wire logic [7:0] regReadData,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWriteData,
   output logic [5:0] gateInput,
   output logic sampleStrobe_n,
   output logic comparator1Output,
   output logic comparator2Output,
   output logic comparator3Output
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle cycles before a write, to act as a slow host.
   int idleGap = 0;

   // Quiet port and inactive strobe from time zero.
   initial begin
      {regWrite, regRead, regAddr, regWriteData, gateInput} = '0;
      {comparator1Output, comparator2Output, comparator3Output} = '0;
      sampleStrobe_n = 1'b1;
   end

   // Data is inverted after release so a stale byte is never reused.
   task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
      repeat (idleGap) @(negedge clk);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWriteData = d;
      @(negedge clk);
      regWrite = 1'b0;
      regWriteData = ~d;
   endtask

   task automatic readReg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      regAddr = ~a;
      @(negedge clk);
      d = regReadData;
   endtask

   // Comparator pins carry the phase code in the pair the mode names.
   task automatic setPins(input logic [5:0] g, input logic s,
      input logic [2:0] cm);
      @(negedge clk);
      gateInput = g;
      sampleStrobe_n = s;
      {comparator1Output, comparator2Output, comparator3Output} = cm;
   endtask
endmodule

// ---- verif/phase_c_select_and_sense_config_tb.sv ----
/*
 * Self-checking bench for the phase-C select and sense block.
 * Assumes host_model drives all inputs but clock and reset, on falling edges.
 */
module phase_c_select_and_sense_config_tb
   import phase_c_cfg_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic regWrite, regRead, sampleStrobe_n, highDriveLevel, lowDriveLevel;
   logic comparator1Output, comparator2Output, comparator3Output;
   logic [7:0] regAddr, regWriteData, regReadData;
   logic [5:0] gateInput, oh;
   logic highDriveEnable, lowDriveEnable, comparator3HysteresisOff;
   logic pumpUvThresholdHigh, backemfGainActive, bemfInputsToReference;
   logic backemfSampling, comparator1Enable, comparator2Enable;
   logic [1:0] backemfGain, senseAmp1Gain, senseAmp2Gain, senseAmp3Gain;
   logic [1:0] bemfPhase, want;
   logic [2:0] senseAmpSampling;
   logic [3:0] comparator1Threshold, comparator2Threshold;
   int mismatches = 0;
   int checks = 0;

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   host_model u_host (.clk, .regReadData, .regWrite, .regRead, .regAddr,
      .regWriteData, .gateInput, .sampleStrobe_n, .comparator1Output,
      .comparator2Output, .comparator3Output);
   phase_c_select_and_sense_config u_dut (.clk, .reset, .regWrite,
      .regRead, .regAddr, .regWriteData, .regReadData, .gateInput,
      .sampleStrobe_n, .comparator1Output, .comparator2Output,
      .comparator3Output, .highDriveLevel, .highDriveEnable, .lowDriveLevel,
      .lowDriveEnable, .comparator3HysteresisOff, .pumpUvThresholdHigh,
      .backemfGain, .backemfGainActive, .senseAmp1Gain, .senseAmp2Gain,
      .senseAmp3Gain, .bemfInputsToReference, .bemfPhase, .backemfSampling,
      .senseAmpSampling, .comparator1Enable, .comparator1Threshold,
      .comparator2Enable, .comparator2Threshold);

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.readReg(a, d);
      chk(d, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic end_sim;
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog: the sequence needs well under a tenth of this span.
   initial begin
      #400us;
      mismatches++;
      end_sim;
   end

   // Main sequence; the drive outputs lag pins by three synced edges.
   initial begin
      settle(5);
      reset = 1'b0;
      rdChk(8'h0c, 8'h36);
      rdChk(8'h0d, 8'haa);
      rdChk(8'h0e, 8'h00);
      rdChk(8'h0f, 8'h88);
      u_host.writeReg(8'h10, 8'hff);
      rdChk(8'h10, 8'h00);
      rdChk(8'h0b, 8'h00);
      for (int i = 0; i < 4; i++) begin
         u_host.idleGap = i;
         u_host.writeReg(8'h0c + 8'(i), 8'h5a ^ 8'(i));
      end
      for (int i = 0; i < 4; i++)
         rdChk(8'h0c + 8'(i), 8'h5a ^ 8'(i));
      u_host.idleGap = 0;
      for (int c = 0; c < 8; c++)
         for (int p = 0; p < 2; p++) begin
            oh = (c > 0 && c < 7) ? 6'h1 << (c - 1) : 6'h3f;
            want = {c != 7, c > 0 && c < 7 && p == 0};
            u_host.setPins(p ? ~oh : oh, 1'b1, 3'h0);
            u_host.writeReg(8'h0c, {c[0], c[2:0], c[1], c[2:0]});
            settle(5);
            chk({4'h0, comparator3HysteresisOff, pumpUvThresholdHigh,
               highDriveEnable, highDriveLevel & highDriveEnable},
               {4'h0, c[0], c[1], want});
            chk({6'h0, lowDriveEnable, lowDriveLevel & lowDriveEnable},
               {6'h0, want});
         end
      for (int g = 0; g < 4; g++) begin
         u_host.writeReg(8'h0d, 8'(g * 8'h55));
         settle(3);
         chk({backemfGain, senseAmp1Gain, senseAmp2Gain, senseAmp3Gain},
            8'(g * 8'h55));
         chk({7'h0, backemfGainActive}, {7'h0, g == 0});
      end
      for (int n = 0; n < 16; n++) begin
         u_host.writeReg(8'h0f, {4'(n), 4'(15 - n)});
         settle(3);
         chk({comparator1Threshold, comparator2Threshold},
            {4'(n), 4'(15 - n)});
         chk({6'h0, comparator1Enable, comparator2Enable},
            {6'h0, n != 0, n != 15});
      end
      // Fixed codes, then the pin-pair modes with the unused pin opposed.
      for (int k = 0; k < 12; k++) begin
         u_host.setPins(6'h0, 1'b1,
            k < 8 ? {k[1], k[0], ~k[0]} : {k[1], ~k[0], k[0]});
         u_host.writeReg(8'h0e, {k[0],
            k < 4 ? 3'h4 + 3'(k) : (k < 8 ? 3'h2 : 3'h3), 4'h0});
         settle(5);
         chk({5'h0, bemfInputsToReference, bemfPhase},
            {5'h0, ~k[0], k[1:0]});
      end
      u_host.writeReg(8'h0e, 8'h00);
      u_host.setPins(6'b110011, 1'b0, 3'h0);
      settle(6);
      chk({6'h0, bemfPhase}, {6'h0, PHASE_B});
      u_host.setPins(6'b110100, 1'b1, 3'h0);
      u_host.writeReg(8'h0e, 8'h10);
      settle(4);
      u_host.setPins(6'b110100, 1'b0, 3'h0);
      settle(6);
      chk({6'h0, bemfPhase}, {6'h0, PHASE_A});
      u_host.setPins(6'b001111, 1'b0, 3'h0);
      settle(6);
      chk({6'h0, bemfPhase}, {6'h0, PHASE_A});
      // Hold mode; back-EMF also waits for the guard after PWM goes high.
      u_host.setPins(6'h01, 1'b1, 3'h0);
      u_host.writeReg(8'h0e, 8'h0f);
      u_host.writeReg(8'h0c, 8'h10);
      settle(5);
      chk({4'h0, backemfSampling, senseAmpSampling}, 8'h00);
      u_host.setPins(6'h01, 1'b0, 3'h0);
      settle(10);
      chk({4'h0, backemfSampling, senseAmpSampling}, 8'h07);
      settle(50);
      chk({4'h0, backemfSampling, senseAmpSampling}, 8'h0f);
      u_host.writeReg(8'h0e, 8'h00);
      u_host.setPins(6'h01, 1'b1, 3'h0);
      settle(5);
      chk({4'h0, backemfSampling, senseAmpSampling}, 8'h0f);
      end_sim;
   end
endmodule
